// ==== hdl/dpsl_pkg.sv ====
// Purpose: constants for the parallel sample latch front end
// Assumes: one sample clock, straight binary 8-bit codes
// Notes: mode codes are one-hot; strap is a two-wire sense of a three-level pin
package dpsl_pkg;
    // ****************************************
    // data format
    // ****************************************
    localparam int DATA_W = 8;                       // sample width
    localparam logic [8:0] CODE_SPAN = 9'h100;       // full-scale divisor 256
    localparam logic [7:0] CODE_MAX = 8'hff;         // all-ones code 255
    localparam int FIFO_DEPTH = 4;                   // words in data path buffer
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 250;                    // fabric clock rate
    localparam int MAX_MSPS = 210;                   // highest sample rate
    // ****************************************
    // clock receiver modes
    // ****************************************
    typedef enum logic [2:0]
    {
        DPSL_MODE_SE   = 3'b001,                     // strap at clock ground
        DPSL_MODE_DIFF = 3'b010,                     // strap at clock supply
        DPSL_MODE_PECL = 3'b100                      // strap floating
    } dpsl_mode_e;
    localparam dpsl_mode_e MODE_RST = DPSL_MODE_PECL; // mode before strap is read
endpackage : dpsl_pkg

// ==== hdl/dpsl_fifo.sv ====
// Purpose: small valid/ready FIFO in the sample path
// Assumes: single clock, async active-low reset
// Notes: read data held in a register; depth must be a power of two
module dpsl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];     // storage
    logic [AW:0] wr_q;                   // write pointer with wrap bit
    logic [AW:0] rd_q;                   // read pointer with wrap bit
    logic [AW:0] fill;                   // words held
    logic push;                          // accepted write
    logic pop;                           // accepted read
    // ****************************************
    // flags
    // ****************************************
    assign fill = wr_q - rd_q;
    assign o_in_ready = (fill != (AW+1)'(DEPTH));
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    // storage write
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end
    // pointers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end
    // registered read port: head word when valid and not yet consumed
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end
        else if (!o_out_valid || pop)
        begin
            // next head is rd+1 if popping, else rd
            if ((fill > (AW+1)'(pop)))
            begin
                o_out_valid <= 1'b1;
                o_out_data <= mem_q[pop ? rd_q[AW-1:0] + 1'b1 : rd_q[AW-1:0]];
            end
            else
            begin
                o_out_valid <= 1'b0;
            end
        end
    end
endmodule : dpsl_fifo

// ==== hdl/dpsl_top.sv ====
// Purpose: sample latch and code front end of an 8-bit current converter
// Assumes: sample clock arrives as a pin and is sampled by the 250 MHz clock
// Notes: outputs are the two complementary current weights, in 1/256 steps
//
// Functional notes
// - eight parallel unsigned bits, msb to lsb
// - capture on rising sample clock; outputs update when a buffered word is taken with i_conv_ready high
// - one sample per clock, up to 210 MSPS; the 250 MHz pin sampling resolves sample clock edges only up to 125 MSPS
// - true gets code, complement gets 255-code
// - clock receiver mode follows mode strap; the strap is read once after reset release and the mode then holds
module dpsl_top
    import dpsl_pkg::*;
#(
    parameter int DEPTH = dpsl_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // sample pins
    input wire logic i_sample_clk,
    input wire logic [dpsl_pkg::DATA_W-1:0] i_data_bits,
    // mode strap sense: tied low, tied high, or floating
    input wire logic i_clock_mode_strap_low,
    input wire logic i_clock_mode_strap_high,
    // converter side
    output logic o_conv_ready,
    input wire logic i_conv_ready,
    output logic o_conv_valid,
    output logic [dpsl_pkg::DATA_W-1:0] o_true_current_output,
    output logic [dpsl_pkg::DATA_W-1:0] o_complementary_current_output,
    output logic [2:0] o_clock_mode,
    output logic o_overrun
);
    import dpsl_pkg::*;
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] clk_sync_q;              // sample clock: two sync stages + edge history
    logic [DATA_W-1:0] dat_s1_q;         // data first stage
    logic [DATA_W-1:0] dat_s2_q;         // data second stage
    logic [1:0] strap_s1_q;              // strap first stage
    logic [1:0] strap_s2_q;              // strap second stage
    logic strap_done_q;                  // strap caught once after reset
    logic rise;                          // rising sample edge seen
    logic [DATA_W-1:0] master_q;         // master stage of the latch
    logic in_ready;                      // fifo can accept
    logic f_valid;                       // fifo head present
    logic [DATA_W-1:0] f_data;           // fifo head word
    dpsl_mode_e mode_q;                  // selected receiver mode
    // sync chain; stage 0 only feeds stage 1
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            clk_sync_q <= '0;
            dat_s1_q <= '0;
            dat_s2_q <= '0;
        end
        else
        begin
            clk_sync_q <= {clk_sync_q[1:0], i_sample_clk};
            dat_s1_q <= i_data_bits;
            dat_s2_q <= dat_s1_q;
        end
    end
    // strap sync runs through reset, so the first edge after release sees the pin
    // a reset here would hand the mode capture a cleared word: always floating
    always_ff @(posedge i_clk)
    begin
        strap_s1_q <= {i_clock_mode_strap_high, i_clock_mode_strap_low};
        strap_s2_q <= strap_s1_q;
    end
    // rising edge from second and third stages
    assign rise = clk_sync_q[1] && !clk_sync_q[2];
    // ****************************************
    // master stage: capture on rising edge
    // ****************************************
    // holds the word between edges whatever the pins do
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            master_q <= '0;
        end
        else if (rise)
        begin
            master_q <= dat_s2_q;
        end
    end
    // one word per edge into the buffer, a cycle after capture
    logic push_q;                        // capture happened last cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            push_q <= 1'b0;
        end
        else
        begin
            push_q <= rise;
        end
    end
    // ****************************************
    // data path buffer
    // ****************************************
    dpsl_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(push_q),
        .i_in_data(master_q),
        .o_in_ready(in_ready),
        .o_out_valid(f_valid),
        .o_out_data(f_data),
        .i_out_ready(i_conv_ready)
    );
    // overrun flag, sticky until reset, and ready mirror
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_overrun <= 1'b0;
            o_conv_ready <= 1'b0;
        end
        else
        begin
            o_conv_ready <= in_ready;
            if (push_q && !in_ready)
            begin
                o_overrun <= 1'b1;
            end
        end
    end
    // ****************************************
    // slave stage: complementary weights
    // ****************************************
    // updates only when a word is handed over, else holds
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_conv_valid <= 1'b0;
            o_true_current_output <= '0;
            o_complementary_current_output <= CODE_MAX;
        end
        else
        begin
            o_conv_valid <= f_valid && i_conv_ready;
            if (f_valid && i_conv_ready)
            begin
                o_true_current_output <= f_data;
                o_complementary_current_output <= CODE_MAX - f_data;
            end
        end
    end
    // ****************************************
    // clock receiver mode from strap
    // ****************************************
    // caught once after reset release, from synchronised strap
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mode_q <= MODE_RST;
            strap_done_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            strap_done_q <= 1'b1;
            unique case (strap_s2_q)
                2'b01: mode_q <= DPSL_MODE_SE;
                2'b10: mode_q <= DPSL_MODE_DIFF;
                default: mode_q <= DPSL_MODE_PECL;
            endcase
        end
    end
    assign o_clock_mode = mode_q;
    // ****************************************
    // checks
    // ****************************************
    property p_capture;
        @(posedge i_clk) disable iff (!i_rst_n)
        rise |=> (master_q == $past(dat_s2_q));
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");
    property p_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        !rise |=> $stable(master_q);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved");
    property p_comp;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_true_current_output + o_complementary_current_output) == CODE_MAX;
    endproperty
    a_comp: assert property (p_comp) else $error("outputs not complementary");
    property p_out_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        !$past(f_valid && i_conv_ready) |-> $stable(o_true_current_output);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved");
    sequence s_edge;
        rise ##1 push_q;
    endsequence
    property p_push;
        @(posedge i_clk) disable iff (!i_rst_n)
        rise |-> s_edge;
    endproperty
    a_push: assert property (p_push) else $error("edge not pushed");
    property p_data;
        @(posedge i_clk) disable iff (!i_rst_n)
        (f_valid && i_conv_ready) |=> (o_true_current_output == $past(f_data));
    endproperty
    a_data: assert property (p_data) else $error("wrong code out");
    property p_mode;
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(strap_done_q) && $past(strap_s2_q) == 2'b01 |-> mode_q == DPSL_MODE_SE;
    endproperty
    a_mode: assert property (p_mode) else $error("mode not single-ended");
    property p_mode_st;
        @(posedge i_clk) disable iff (!i_rst_n)
        strap_done_q && $past(strap_done_q) |-> $stable(mode_q);
    endproperty
    a_mode_st: assert property (p_mode_st) else $error("mode changed");
endmodule : dpsl_top

// ==== verification/dpsl_src.sv ====
// Purpose: sample source model driving the clock and data pins
// Assumes: bench calls send from a falling edge of i_clk
// Notes: data is inverted after each word so a stale value never matches
module dpsl_src
(
    // clock
    input wire logic i_clk,
    // sample pins
    output logic o_sample_clk,
    output logic [7:0] o_data_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    // sample clock stands low between words
    initial
    begin
        o_sample_clk = 1'b0;
        o_data_bits = 8'h00;
    end
    // one word: data while low, full-swing rise, fall, then scramble
    task automatic send(input logic [7:0] d);
        @(negedge i_clk);
        o_data_bits = d;
        repeat (3) @(negedge i_clk);
        o_sample_clk = 1'b1;
        repeat (2) @(negedge i_clk);
        o_sample_clk = 1'b0;
        o_data_bits = ~d;
    endtask : send
endmodule : dpsl_src

// ==== verification/dpsl_top_tb.sv ====
// Purpose: self-checking bench for the sample latch front end
// Assumes: converter side driven here, source model on the pins
// Notes: expected codes queued at send, popped on each valid pulse
module dpsl_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dpsl_pkg::*;
    logic clk, rst_n, sclk, strap_low, strap_high, ready, conv_rdy, valid, ovr, mon_on;
    logic [7:0] data, tru, cmp, e, last, r;
    logic [2:0] mode;
    logic [7:0] exp_q[$]; // expected codes
    int error_cnt, num_checks, seed;
    // strap low/high pairs and the mode each selects
    logic [1:0] strap_tab[4] = '{2'b10, 2'b01, 2'b00, 2'b11};
    dpsl_mode_e mode_tab[4] = '{DPSL_MODE_SE, DPSL_MODE_DIFF, DPSL_MODE_PECL, DPSL_MODE_PECL};
    logic [7:0] codes[4] = '{8'h00, 8'hff, 8'h80, 8'h01};
    dpsl_src src (.i_clk(clk), .o_sample_clk(sclk), .o_data_bits(data));
    dpsl_top #(.DEPTH(FIFO_DEPTH)) DUT (.i_clk(clk), .i_rst_n(rst_n), .i_sample_clk(sclk),
        .i_data_bits(data), .i_clock_mode_strap_low(strap_low),
        .i_clock_mode_strap_high(strap_high), .o_conv_ready(conv_rdy), .i_conv_ready(ready),
        .o_conv_valid(valid), .o_true_current_output(tru),
        .o_complementary_current_output(cmp), .o_clock_mode(mode), .o_overrun(ovr));
    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    // reset with a strap setting, then check the selected mode
    task automatic do_reset(input int m);
        rst_n = 1'b0;
        {strap_low, strap_high} = strap_tab[m];
        repeat (10) @(negedge clk);
        check("rst true", 8'h00, tru);
        check("rst comp", CODE_MAX, cmp);
        check("rst valid", 8'h00, {7'h0, valid});
        check("rst ready", 8'h00, {7'h0, conv_rdy});
        check("rst overrun", 8'h00, {7'h0, ovr});
        check("rst mode", {5'h0, MODE_RST}, {5'h0, mode});
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check("mode", {5'h0, mode_tab[m]}, {5'h0, mode});
    endtask : do_reset
    task automatic send_word(input logic [7:0] d);
        exp_q.push_back(d);
        src.send(d);
    endtask : send_word
    // bounded wait until every queued code has come out
    task automatic wait_drain();
        for (int k = 0; k < 300 && exp_q.size() != 0; k++)
            @(negedge clk);
        check("left", 8'h00, 8'(exp_q.size()));
    endtask : wait_drain
    // monitor: compare on valid, otherwise the true output must hold; looks at the
    // falling edge so the registered outputs have settled
    always @(negedge clk)
    begin
        if (rst_n && mon_on && valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("spare valid", 8'h00, 8'h01);
            else
            begin
                e = exp_q.pop_front();
                check("true", e, tru);
                check("comp", CODE_MAX - e, cmp);
            end
        end
        else if (rst_n && mon_on)
            check("hold", last, tru);
        last <= tru;
    end
    // watchdog
    initial
    begin
        #20000;
        error_cnt++;
        $display("BAD watchdog expected done seen hang");
        give_verdict();
    end
    initial
    begin
        seed = 99;
        error_cnt = 0;
        num_checks = 0;
        mon_on = 1'b0;
        ready = 1'b1;
        for (int m = 0; m < 4; m++)
            do_reset(m);
        $display("mode test done");
        mon_on = 1'b1;
        foreach (codes[i])
            send_word(codes[i]);
        repeat (20)
        begin
            r = 8'($random(seed));
            send_word(r);
        end
        wait_drain();
        $display("code test done");
        ready = 1'b0;
        repeat (3)
        begin
            r = 8'($random(seed));
            send_word(r);
        end
        repeat (8) @(negedge clk);
        ready = 1'b1;
        wait_drain();
        $display("stall test done");
        mon_on = 1'b0;
        ready = 1'b0;
        repeat (8) src.send(8'h5a);
        repeat (4) @(negedge clk);
        check("overrun", 8'h01, {7'h0, ovr});
        check("full ready", 8'h00, {7'h0, conv_rdy});
        ready = 1'b1;
        repeat (20) @(negedge clk);
        check("overrun sticky", 8'h01, {7'h0, ovr});
        check("free ready", 8'h01, {7'h0, conv_rdy});
        $display("overrun test done");
        give_verdict();
    end
endmodule : dpsl_top_tb
